// ===== rtl/seq_pkg.sv
/*
  Shared constants for the program sequencer: register offsets, reset
  values, instruction encodings, ALU operation codes and stack sizing.
  Assumes a single 10 MHz clock and a 16-bit wide program flash.
*/
package seq_pkg;

  // ----------------------------------------------------------------
  // sizing of the 64K-word variant
  // ----------------------------------------------------------------
  localparam int unsigned PC_W = 13;
  localparam int unsigned BANK_W = 3;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned STACK_DEPTH = 16;
  localparam logic [4:0] STACK_FULL_CNT = 5'h10;

  // ----------------------------------------------------------------
  // register map, byte offsets on the AXI4-Lite port
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PCBYTE = 8'h00;
  localparam logic [7:0] OFS_TBLP = 8'h04;
  localparam logic [7:0] OFS_TBHP = 8'h08;
  localparam logic [7:0] OFS_TBHI = 8'h0C;
  localparam logic [7:0] OFS_BANK = 8'h10;
  localparam logic [7:0] OFS_ACC = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam int unsigned STAT_C_BIT = 0;
  localparam int unsigned STAT_Z_BIT = 1;
  localparam int unsigned STAT_IRQ_BIT = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // reset values and vectors
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] RESET_VEC = 16'h0000;
  localparam logic [ADDR_W-1:0] INT_VEC = 16'h0004;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // ----------------------------------------------------------------
  // instruction classes, held in word bits 15..12; branch class in bits 15..14, call flag in bit 13
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_ALU = 4'h1;
  localparam logic [3:0] OP_RSUB = 4'h2;
  localparam logic [3:0] OP_RINT = 4'h3;
  localparam logic [3:0] OP_SKIP = 4'h4;
  localparam logic [3:0] OP_MOVPCL = 4'h5;
  localparam logic [3:0] OP_TBLRD = 4'h6;
  localparam logic [1:0] OP_BRANCH = 2'h3;
  localparam int unsigned CALL_BIT = 13;

  // ----------------------------------------------------------------
  // ALU operation codes, held in word bits 11..8
  // ----------------------------------------------------------------
  localparam logic [3:0] ALU_ADD = 4'h0;
  localparam logic [3:0] ALU_ADC = 4'h1;
  localparam logic [3:0] ALU_SUB = 4'h2;
  localparam logic [3:0] ALU_SBC = 4'h3;
  localparam logic [3:0] ALU_AND = 4'h4;
  localparam logic [3:0] ALU_OR = 4'h5;
  localparam logic [3:0] ALU_XOR = 4'h6;
  localparam logic [3:0] ALU_CPL = 4'h7;
  localparam logic [3:0] ALU_RR = 4'h8;
  localparam logic [3:0] ALU_RRC = 4'h9;
  localparam logic [3:0] ALU_RL = 4'hA;
  localparam logic [3:0] ALU_RLC = 4'hB;
  localparam logic [3:0] ALU_INC = 4'hC;
  localparam logic [3:0] ALU_DEC = 4'hD;
  localparam logic [3:0] ALU_DADJ = 4'hE;
  localparam logic [3:0] ALU_MOV = 4'hF;

  // ----------------------------------------------------------------
  // phase of the instruction cycle
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_T1 = 2'b00,
    PH_T2 = 2'b01,
    PH_T3 = 2'b10,
    PH_T4 = 2'b11
  } phase_e;

endpackage

// ===== rtl/program_sequencer_stack.sv
/*
  Program sequencer of an 8-bit core: four-phase instruction cycle,
  fetch/execute overlap, banked program counter, return stack, table
  read and a compact ALU, with an AXI4-Lite register port.
  Assumes flash data is valid by the last phase of the cycle in which
  its address is shown, and that irq_req_i is already enable-gated.
*/
`timescale 1ns/1ps

// Operation
// - four non-overlapping phases T1..T4 make up one instruction cycle
// - counter advances at start of T1 with the fetch; T2..T4 execute
// - fetch overlaps execute; counter-changing instructions cost one extra cycle
// - counter steps by one per instruction except on jumps, calls, returns, interrupts and counter writes
// - a taken skip discards the prefetched word and runs a dummy cycle
// - full address is bank bits above a 13-bit in-bank counter
// - only the low counter byte is software visible; writes jump within page
// - low byte write acts as a branch with a dummy cycle
// - jumps, calls, interrupts and reset load their target directly
// - stack holds counter values only; entries and pointer are not accessible
// - call or interrupt acknowledge pushes; returns pop the counter
// - after reset the stack pointer indicates the top of stack
// - with stack full an interrupt is recorded but held until a return
// - a call with stack full still runs and loses the oldest entry
// - stack depth is 12 or 16 levels by variant; 16 here
// - 8-bit ALU computes results and updates carry and zero status
// - ALU offers add, subtract, adjust, logic, rotates, inc, dec, skip tests
// - program memory is 16 bits wide, banked per variant
// - after reset execution begins at address zero
// - table pointer low and high registers form the full table address
// - table read puts low byte in a data register and high byte in latch
// - every table read takes two instruction cycles
module program_sequencer_stack (
  // clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // program flash
  output logic [15:0] flash_addr_o,
  input wire logic [15:0] flash_data_i,
  // interrupt logic
  input wire logic irq_req_i,
  output logic int_ack_o,
  // phase clocks, one-hot T1..T4
  output logic [3:0] phase_o
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    seq_pkg::phase_e ph;
    logic [12:0] pc;
    logic [2:0] bank;
    logic [15:0] faddr;
    logic [15:0] ir;
    logic ir_ok;
    logic tab;
    logic [7:0] acc;
    logic cy;
    logic zf;
    logic [7:0] tblp;
    logic [7:0] tbhp;
    logic [7:0] tbhi;
    logic [3:0] wptr;
    logic [4:0] cnt;
    logic [15:0][15:0] stk;
    logic int_pend;
    logic int_ack;
    logic jmp_pend;
    logic [7:0] jmp_val;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } state_s;

  state_s state_r;
  state_s state_nxt;
  logic wr_go;

  // ------------------------------------------------------------------
  // alu: returns {carry, result}
  // ------------------------------------------------------------------
  function automatic logic [8:0] alu_f(input logic [3:0] op, input logic [7:0] a,
                                       input logic [7:0] b, input logic c);
    logic [8:0] r;
    logic [8:0] t;
    r = {c, a};
    t = 9'h000;
    case (op)
      seq_pkg::ALU_ADD: r = {1'b0, a} + {1'b0, b};
      seq_pkg::ALU_ADC: r = {1'b0, a} + {1'b0, b} + {8'h00, c};
      // carry set means no borrow
      seq_pkg::ALU_SUB: r = {1'b0, a} + {1'b0, ~b} + 9'h001;
      seq_pkg::ALU_SBC: r = {1'b0, a} + {1'b0, ~b} + {8'h00, c};
      seq_pkg::ALU_AND: r = {c, a & b};
      seq_pkg::ALU_OR: r = {c, a | b};
      seq_pkg::ALU_XOR: r = {c, a ^ b};
      seq_pkg::ALU_CPL: r = {c, ~a};
      seq_pkg::ALU_RR: r = {c, a[0], a[7:1]};
      seq_pkg::ALU_RRC: r = {a[0], c, a[7:1]};
      seq_pkg::ALU_RL: r = {c, a[6:0], a[7]};
      seq_pkg::ALU_RLC: r = {a[7], a[6:0], c};
      seq_pkg::ALU_INC: r = {c, a + 8'h01};
      seq_pkg::ALU_DEC: r = {c, a - 8'h01};
      seq_pkg::ALU_DADJ:
      begin
        t = {c, a};
        if (t[3:0] > 4'h9)
        begin
          t = t + 9'h006;
        end
        if (t[8] || (t[7:4] > 4'h9))
        begin
          t = {1'b1, t[7:0] + 8'h60};
        end
        r = t;
      end
      default: r = {c, b};
    endcase
    return r;
  endfunction

  // ------------------------------------------------------------------
  // bus handshakes
  // ------------------------------------------------------------------
  // address and data are taken together, so neither can run ahead
  assign wr_go = s_axi_awvalid_i & s_axi_wvalid_i & ~state_r.bvalid;
  assign s_axi_awready_o = wr_go;
  assign s_axi_wready_o = wr_go;
  assign s_axi_arready_o = ~state_r.rvalid;
  assign s_axi_bvalid_o = state_r.bvalid;
  assign s_axi_bresp_o = state_r.bresp;
  assign s_axi_rvalid_o = state_r.rvalid;
  assign s_axi_rresp_o = state_r.rresp;
  assign s_axi_rdata_o = state_r.rdata;

  // ------------------------------------------------------------------
  // flash, interrupt and phase outputs
  // ------------------------------------------------------------------
  assign flash_addr_o = state_r.faddr;
  assign int_ack_o = state_r.int_ack;
  // one phase high per clock, never two at once
  assign phase_o = 4'h1 << state_r.ph;

  // ------------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------------
  always_comb
  begin
    logic [12:0] npc;
    logic [2:0] nbank;
    logic [3:0] pidx;
    logic [8:0] alu;
    logic [7:0] sacc;
    logic flush;
    logic busy;
    npc = state_r.pc;
    nbank = state_r.bank;
    pidx = state_r.wptr - 4'h1;
    alu = 9'h000;
    sacc = state_r.acc;
    flush = 1'b0;
    busy = 1'b0;
    state_nxt = state_r;
    state_nxt.int_ack = 1'b0;

    // phase walks T1..T4 and wraps
    state_nxt.ph = seq_pkg::phase_e'(state_r.ph + 2'h1);

    // all sequencing happens at the T4 edge, i.e. at the start of T1
    if (state_r.ph == seq_pkg::PH_T4)
    begin
      if (state_r.tab)
      begin
        // second cycle of a table read: fetched word is table data
        state_nxt.acc = flash_data_i[7:0];
        state_nxt.tbhi = flash_data_i[15:8];
        state_nxt.tab = 1'b0;
      end
      else
      begin
        // the word fetched in this cycle becomes the next to execute
        state_nxt.ir = flash_data_i;
        if (state_r.ir_ok)
        begin
          if (state_r.ir[15:14] == seq_pkg::OP_BRANCH)
          begin
            // jump or call: target loaded, prefetch flushed
            npc = state_r.ir[12:0];
            flush = 1'b1;
            busy = 1'b1;
            if (state_r.ir[seq_pkg::CALL_BIT])
            begin
              // full stack still pushes and overwrites the oldest
              state_nxt.stk[state_r.wptr] = state_r.faddr;
              state_nxt.wptr = state_r.wptr + 4'h1;
              if (state_r.cnt != seq_pkg::STACK_FULL_CNT)
              begin
                state_nxt.cnt = state_r.cnt + 5'h01;
              end
            end
          end
          else
          begin
            case (state_r.ir[15:12])
              seq_pkg::OP_ALU:
              begin
                alu = alu_f(state_r.ir[11:8], state_r.acc, state_r.ir[7:0], state_r.cy);
                state_nxt.acc = alu[7:0];
                state_nxt.cy = alu[8];
                state_nxt.zf = (alu[7:0] == 8'h00);
              end
              seq_pkg::OP_RSUB, seq_pkg::OP_RINT:
              begin
                {nbank, npc} = state_r.stk[pidx];
                state_nxt.wptr = pidx;
                if (state_r.cnt != 5'h00)
                begin
                  state_nxt.cnt = state_r.cnt - 5'h01;
                end
                flush = 1'b1;
                busy = 1'b1;
              end
              seq_pkg::OP_SKIP:
              begin
                // bit1 increments, bit2 decrements, bit0 inverts the test
                if (state_r.ir[1])
                begin
                  sacc = state_r.acc + 8'h01;
                end
                else if (state_r.ir[2])
                begin
                  sacc = state_r.acc - 8'h01;
                end
                state_nxt.acc = sacc;
                if ((sacc == 8'h00) != state_r.ir[0])
                begin
                  flush = 1'b1;
                end
              end
              seq_pkg::OP_MOVPCL:
              begin
                npc = {state_r.faddr[12:8], state_r.acc};
                flush = 1'b1;
                busy = 1'b1;
              end
              seq_pkg::OP_TBLRD:
              begin
                state_nxt.tab = 1'b1;
              end
              default:
              begin
                state_nxt.ir = flash_data_i;
              end
            endcase
          end
        end

        // a bus write to the low byte behaves like a jump in the page
        if (!busy && !state_nxt.tab && state_r.jmp_pend)
        begin
          npc = {state_r.faddr[12:8], state_r.jmp_val};
          state_nxt.jmp_pend = 1'b0;
          flush = 1'b1;
          busy = 1'b1;
        end

        // interrupt waits while the stack is full or a skip discards
        if (!busy && !flush && !state_nxt.tab && state_r.int_pend &&
            (state_r.cnt != seq_pkg::STACK_FULL_CNT))
        begin
          state_nxt.stk[state_r.wptr] = state_r.faddr;
          state_nxt.wptr = state_r.wptr + 4'h1;
          state_nxt.cnt = state_r.cnt + 5'h01;
          {nbank, npc} = seq_pkg::INT_VEC;
          state_nxt.int_pend = 1'b0;
          state_nxt.int_ack = 1'b1;
          flush = 1'b1;
        end

        state_nxt.ir_ok = ~flush;
      end

      // next fetch address and counter step
      if (state_nxt.tab)
      begin
        state_nxt.faddr = {state_r.tbhp, state_r.tblp};
        state_nxt.pc = npc;
      end
      else
      begin
        state_nxt.faddr = {nbank, npc};
        state_nxt.pc = npc + 13'h0001;
      end
      state_nxt.bank = nbank;
    end

    // request flag: a new request wins over an acknowledge
    if (irq_req_i)
    begin
      state_nxt.int_pend = 1'b1;
    end

    // write response retires before a new write is taken
    if (state_r.bvalid && s_axi_bready_i)
    begin
      state_nxt.bvalid = 1'b0;
    end

    // register writes; the stack has no address at all
    if (wr_go)
    begin
      state_nxt.bvalid = 1'b1;
      state_nxt.bresp = seq_pkg::RESP_OKAY;
      if (s_axi_awaddr_i == seq_pkg::OFS_PCBYTE)
      begin
        if (s_axi_wstrb_i[0])
        begin
          state_nxt.jmp_pend = 1'b1;
          state_nxt.jmp_val = s_axi_wdata_i[7:0];
        end
      end
      else if (s_axi_awaddr_i == seq_pkg::OFS_TBLP)
      begin
        if (s_axi_wstrb_i[0])
        begin
          state_nxt.tblp = s_axi_wdata_i[7:0];
        end
      end
      else if (s_axi_awaddr_i == seq_pkg::OFS_TBHP)
      begin
        if (s_axi_wstrb_i[0])
        begin
          state_nxt.tbhp = s_axi_wdata_i[7:0];
        end
      end
      else if (s_axi_awaddr_i == seq_pkg::OFS_TBHI)
      begin
        // the table load in the same cycle keeps priority
        if (s_axi_wstrb_i[0] && !(state_r.tab && state_r.ph == seq_pkg::PH_T4))
        begin
          state_nxt.tbhi = s_axi_wdata_i[7:0];
        end
      end
      else if (s_axi_awaddr_i == seq_pkg::OFS_BANK)
      begin
        // bank change takes effect at the next fetch; a write during T4 is dropped
        if (s_axi_wstrb_i[0] && state_r.ph != seq_pkg::PH_T4)
        begin
          state_nxt.bank = s_axi_wdata_i[2:0];
        end
      end
      else if ((s_axi_awaddr_i == seq_pkg::OFS_ACC) ||
               (s_axi_awaddr_i == seq_pkg::OFS_STATUS))
      begin
        state_nxt.bresp = seq_pkg::RESP_OKAY;
      end
      else
      begin
        state_nxt.bresp = seq_pkg::RESP_SLVERR;
      end
    end

    // read data retires, then a new read is taken
    if (state_r.rvalid && s_axi_rready_i)
    begin
      state_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && !state_r.rvalid)
    begin
      state_nxt.rvalid = 1'b1;
      state_nxt.rresp = seq_pkg::RESP_OKAY;
      state_nxt.rdata = 32'h0000_0000;
      if (s_axi_araddr_i == seq_pkg::OFS_PCBYTE)
      begin
        state_nxt.rdata[7:0] = state_r.faddr[7:0];
      end
      else if (s_axi_araddr_i == seq_pkg::OFS_TBLP)
      begin
        state_nxt.rdata[7:0] = state_r.tblp;
      end
      else if (s_axi_araddr_i == seq_pkg::OFS_TBHP)
      begin
        state_nxt.rdata[7:0] = state_r.tbhp;
      end
      else if (s_axi_araddr_i == seq_pkg::OFS_TBHI)
      begin
        state_nxt.rdata[7:0] = state_r.tbhi;
      end
      else if (s_axi_araddr_i == seq_pkg::OFS_BANK)
      begin
        state_nxt.rdata[2:0] = state_r.bank;
      end
      else if (s_axi_araddr_i == seq_pkg::OFS_ACC)
      begin
        state_nxt.rdata[7:0] = state_r.acc;
      end
      else if (s_axi_araddr_i == seq_pkg::OFS_STATUS)
      begin
        state_nxt.rdata[seq_pkg::STAT_C_BIT] = state_r.cy;
        state_nxt.rdata[seq_pkg::STAT_Z_BIT] = state_r.zf;
        state_nxt.rdata[seq_pkg::STAT_IRQ_BIT] = state_r.int_pend;
      end
      else
      begin
        state_nxt.rresp = seq_pkg::RESP_SLVERR;
      end
    end
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  // stack contents are not cleared: only the pointer matters after reset
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      state_r <= state_nxt;
      state_r.ph <= seq_pkg::PH_T1;
      state_r.faddr <= seq_pkg::RESET_VEC;
      state_r.pc <= 13'h0001;
      state_r.bank <= 3'h0;
      state_r.ir <= 16'h0000;
      state_r.ir_ok <= 1'b0;
      state_r.tab <= 1'b0;
      state_r.acc <= seq_pkg::BYTE_RST;
      state_r.cy <= 1'b0;
      state_r.zf <= 1'b0;
      state_r.tblp <= seq_pkg::BYTE_RST;
      state_r.tbhp <= seq_pkg::BYTE_RST;
      state_r.tbhi <= seq_pkg::BYTE_RST;
      state_r.wptr <= 4'h0;
      state_r.cnt <= 5'h00;
      state_r.int_pend <= 1'b0;
      state_r.int_ack <= 1'b0;
      state_r.jmp_pend <= 1'b0;
      state_r.jmp_val <= seq_pkg::BYTE_RST;
      state_r.bvalid <= 1'b0;
      state_r.bresp <= seq_pkg::RESP_OKAY;
      state_r.rvalid <= 1'b0;
      state_r.rresp <= seq_pkg::RESP_OKAY;
      state_r.rdata <= 32'h0000_0000;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

endmodule

// ===== tb/seq_props.sv
/*
  Checker for the program sequencer, watching only its top ports.
  Assumes one clock domain and the synchronous active-high reset.
*/
`timescale 1ns/1ps

module seq_props (
  // clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // register port
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // sequencer
  input wire logic [15:0] flash_addr_o,
  input wire logic int_ack_o,
  input wire logic [3:0] phase_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  // ----------------------------------------------------------------
  // phases and fetch timing
  // ----------------------------------------------------------------
  phase_order_a: assert property (phase_o == 4'h1 |=> phase_o == 4'h2 ##1 phase_o == 4'h4
    ##1 phase_o == 4'h8 ##1 phase_o == 4'h1) else $error("phase order broken");
  phase_onehot_a: assert property ($onehot(phase_o)) else $error("phase not one-hot");
  fetch_hold_a: assert property (phase_o != 4'h8 |=> $stable(flash_addr_o))
    else $error("fetch address moved outside the cycle boundary");
  reset_vector_a: assert property (disable iff (1'b0) srst_i |=> flash_addr_o == 16'h0000
    && phase_o == 4'h1) else $error("reset does not restart at zero");
  // acknowledge lands at the vector in the first phase
  ack_vector_a: assert property (int_ack_o |-> phase_o == 4'h1 && flash_addr_o == 16'h0004)
    else $error("acknowledge without vector fetch");
  ack_pulse_a: assert property (int_ack_o |=> !int_ack_o [*3])
    else $error("acknowledge longer than one pulse");

  // ----------------------------------------------------------------
  // register port responses
  // ----------------------------------------------------------------
  slverr_resp_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_awaddr_i > 8'h18
    |=> s_axi_bvalid_o && s_axi_bresp_o == 2'h2) else $error("unmapped write not refused");
  bresp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o
    && $stable(s_axi_bresp_o)) else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
    && $stable(s_axi_rdata_o)) else $error("read data dropped early");
endmodule

bind program_sequencer_stack seq_props seq_props_i (.mclk_i(mclk_i), .srst_i(srst_i),
  .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_bresp_o(s_axi_bresp_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .flash_addr_o(flash_addr_o), .int_ack_o(int_ack_o),
  .phase_o(phase_o));

// ===== tb/flash_model.sv
/*
  Far side of the sequencer: a small program flash image and a request line.
  Assumes code stays in page 0 of bank 0; the request is a one-cycle pulse.
*/
`timescale 1ns/1ps

module flash_model (
  // clock
  input wire logic mclk_i,
  // flash side
  input wire logic [15:0] flash_addr_i,
  output logic [15:0] flash_data_o,
  // interrupt side
  input wire logic irq_set_i,
  output logic irq_req_o
);
  logic [15:0] mem [256];

  // ----------------------------------------------------------------
  // program: mov, call, return, jump loop, nop loop, return at the vector
  // ----------------------------------------------------------------
  initial
  begin
    foreach (mem[i]) mem[i] = 16'h0000;
    mem[8'h00] = 16'h1F5A;
    mem[8'h02] = 16'hE010;
    mem[8'h03] = 16'hC020;
    mem[8'h04] = 16'h3000;
    mem[8'h10] = 16'h2000;
    mem[8'h20] = 16'hC020;
    mem[8'h34] = 16'hC030;
  end

  // whole 16-bit words; a held level would re-arm the flag after each service
  assign flash_data_o = mem[flash_addr_i[7:0]];
  always @(posedge mclk_i)
    irq_req_o <= irq_set_i;
endmodule

// ===== tb/tb_top.sv
/*
  Self-checking bench: fetch order through a queue, register port tasks.
  Assumes the flash model image and a 10 MHz clock.
*/
`timescale 1ns/1ps

module tb_top;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic irq_set = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, int_ack, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rnd;
  logic [15:0] faddr, fdata;
  logic [3:0] phase;
  logic [15:0] fq [$];
  logic [1:0] bq [$];
  logic [33:0] rq [$];
  logic [33:0] re;
  int failures = 0;
  int check_count = 0;
  int n;
  integer seed = 32'h856DA41E;

  always #50 mclk_i = ~mclk_i;

  program_sequencer_stack program_sequencer_stack_i (.mclk_i(mclk_i), .srst_i(srst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .flash_addr_o(faddr),
    .flash_data_i(fdata), .irq_req_i(irq), .int_ack_o(int_ack), .phase_o(phase));
  flash_model flash_model_i (.mclk_i(mclk_i), .flash_addr_i(faddr), .flash_data_o(fdata),
    .irq_set_i(irq_set), .irq_req_o(irq));

  // ----------------------------------------------------------------
  // comparison, verdict and register port tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // address and data offered together, each released once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge mclk_i);
    bq.push_back(e);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge mclk_i); while (awready !== 1'b1 || wready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    @(posedge mclk_i);
    bready <= 1'b1;
    do @(posedge mclk_i); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge mclk_i);
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge mclk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    @(posedge mclk_i);
    rready <= 1'b1;
    do @(posedge mclk_i); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // monitor: oldest note against each fetch and each response
  // ----------------------------------------------------------------
  always @(posedge mclk_i)
  begin
    if (!srst_i && phase === 4'h1 && fq.size() > 0)
      check("fetch address", {16'h0000, faddr}, {16'h0000, fq.pop_front()});
    if (bvalid === 1'b1 && bready === 1'b1 && bq.size() > 0)
      check("write response", {30'h0, bresp}, {30'h0, bq.pop_front()});
    if (rvalid === 1'b1 && rready === 1'b1 && rq.size() > 0)
    begin
      re = rq.pop_front();
      check("read response", {30'h0, rresp}, {30'h0, re[33:32]});
      check("read data", rdata, re[31:0]);
    end
  end

  // hang guard, generous against the under two hundred cycles needed
  initial
  begin
    repeat (4000) @(posedge mclk_i);
    failures++;
    finish_test();
  end

  initial
  begin
    // reset vector, call, return and jump in fetch order
    fq = {16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0010, 16'h0011, 16'h0003,
      16'h0004, 16'h0020, 16'h0021, 16'h0020, 16'h0021};
    repeat (4) @(posedge mclk_i);
    srst_i <= 1'b0;
    for (n = 0; n < 200 && fq.size() != 0; n++) @(posedge mclk_i);
    axi_rd(seq_pkg::OFS_ACC, {seq_pkg::RESP_OKAY, 32'h0000005A});
    axi_wr(seq_pkg::OFS_ACC, 32'h000000FF, seq_pkg::RESP_OKAY);
    axi_rd(seq_pkg::OFS_ACC, {seq_pkg::RESP_OKAY, 32'h0000005A});
    rnd = $random(seed);
    axi_wr(seq_pkg::OFS_TBHI, rnd, seq_pkg::RESP_OKAY);
    axi_rd(seq_pkg::OFS_TBHI, {seq_pkg::RESP_OKAY, 24'h000000, rnd[7:0]});
    axi_wr(8'h40, rnd, seq_pkg::RESP_SLVERR);
    axi_rd(8'h40, {seq_pkg::RESP_SLVERR, 32'h00000000});
    // low byte write jumps inside the page, bank and upper bits kept
    axi_wr(seq_pkg::OFS_PCBYTE, 32'h00000030, seq_pkg::RESP_OKAY);
    for (n = 0; n < 200 && !(phase === 4'h1 && faddr === 16'h0030); n++) @(posedge mclk_i);
    @(negedge mclk_i);
    check("page jump", {16'h0000, faddr}, 32'h00000030);
    fq.push_back(16'h0031);
    for (n = 0; n < 200 && fq.size() != 0; n++) @(posedge mclk_i);
    // one request pulse must be acknowledged at the vector
    @(posedge mclk_i);
    irq_set <= 1'b1;
    @(posedge mclk_i);
    irq_set <= 1'b0;
    for (n = 0; n < 200 && int_ack !== 1'b1; n++) @(posedge mclk_i);
    check("interrupt ack", {31'h0, int_ack}, 32'h00000001);
    repeat (40) @(posedge mclk_i);
    check("fetch queue drained", fq.size(), 32'h00000000);
    finish_test();
  end
endmodule
